// ---- core/budc_counter.sv ----
// Four-bit binary up/down counter with cascade chain and AHB-Lite control
`timescale 1ns/1ps
`include "budc_params.svh"

module budc_counter (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Cascade chain, same clock as the neighbouring stages
	input wire logic carry_in_n_i,
	output logic carry_out_n_o,
	// Count outputs
	output logic count_bit0_o,
	output logic count_bit1_o,
	output logic count_bit2_o,
	output logic count_bit3_o
);

	budc_pkg::budc_ctrl_t ctrl;
	budc_pkg::budc_ctrl_t next_ctrl;
	budc_pkg::budc_stat_t stat;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [3:0] count_view;
	logic at_term;
	logic counting;
	logic ctrl_wr;
	logic [31:0] wdata;
	logic [31:0] ctrl_word;
	logic [31:0] stat_word;

	// Bus front end
	budc_ahb_slave u_bus (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(hsize_i),
		.hwdata_i(hwdata_i),
		.hready_i(hready_i),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.ctrl_word_i(ctrl_word),
		.stat_word_i(stat_word),
		.ctrl_wr_o(ctrl_wr),
		.wdata_o(wdata)
	);

	// Control register; next value is read back so a write then read is never stale
	always_comb begin
		next_ctrl = ctrl;
		if (ctrl_wr) begin
			next_ctrl.up = wdata[`BUDC_CTRL_UP];
			next_ctrl.load = wdata[`BUDC_CTRL_LOAD];
			next_ctrl.clear = wdata[`BUDC_CTRL_CLEAR];
			next_ctrl.preset = wdata[`BUDC_CTRL_PRE_HI:`BUDC_CTRL_PRE_LO];
		end
		next_ctrl.spare = 1'b0;
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			ctrl <= `BUDC_CTRL_RST;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// Clear outranks load, and both outrank the chain input
	assign counting = ~ctrl.clear & ~ctrl.load & ~carry_in_n_i;

	// Count state
	always_comb begin
		next_cnt = cnt;
		if (ctrl.clear) begin
			next_cnt = `BUDC_CNT_RST; // see [R5]
		end else if (ctrl.load) begin
			next_cnt = ctrl.preset; // see [R4] see [R8]
		end else if (!carry_in_n_i) begin
			if (ctrl.up) begin
				next_cnt = cnt + `BUDC_CNT_STEP; // see [R1] see [R2]
			end else begin
				next_cnt = cnt - `BUDC_CNT_STEP; // see [R1] see [R2]
			end
		end
		// Chain input high: clock edge ignored, see [R3]
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			cnt <= `BUDC_CNT_RST;
		end else begin
			cnt <= next_cnt;
		end
	end

	// Clear and load act without waiting for an edge, so they override the stored count
	always_comb begin
		count_view = cnt;
		if (ctrl.clear) begin
			count_view = `BUDC_CNT_RST; // see [R5]
		end else if (ctrl.load) begin
			count_view = ctrl.preset; // see [R4]
		end
	end

	// Bit 0 is the least significant, see [R6]
	assign count_bit0_o = count_view[0];
	assign count_bit1_o = count_view[1];
	assign count_bit2_o = count_view[2];
	assign count_bit3_o = count_view[3];

	// Terminal count depends on direction; gated by our own chain input so the
	// stage above steps only when every stage below is at its end
	assign at_term = ctrl.up ? (count_view == `BUDC_TC_UP) : (count_view == `BUDC_TC_DOWN);
	assign carry_out_n_o = ~(at_term & counting); // see [R7] see [R11]

	// Status view for software
	assign stat.count = count_view;
	assign stat.cout_n = carry_out_n_o;
	assign stat.cin_n = carry_in_n_i;
	assign stat_word = {26'h0, stat};
	assign ctrl_word = {24'h000000, next_ctrl};

	// Checks on the counting behaviour
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);

	chk_count_up: assert property ( // see [R1]
		counting && ctrl.up |=> cnt == 4'($past(cnt) + `BUDC_CNT_STEP))
		else $error("count did not step up");

	chk_count_down: assert property ( // see [R2]
		counting && !ctrl.up |=> cnt == 4'($past(cnt) - `BUDC_CNT_STEP))
		else $error("count did not step down");

	chk_inhibit_hold: assert property ( // see [R3]
		carry_in_n_i && !ctrl.load && !ctrl.clear |=> cnt == $past(cnt))
		else $error("count moved while chain input high");

	chk_load_copy: assert property ( // see [R4]
		ctrl.load && !ctrl.clear |-> count_view == ctrl.preset ##1 (!ctrl.load || cnt == $past(ctrl.preset)))
		else $error("load did not copy preset");

	chk_clear_zero: assert property ( // see [R5]
		ctrl.clear |-> {count_bit3_o, count_bit2_o, count_bit1_o, count_bit0_o} == `BUDC_CNT_RST
		##1 cnt == `BUDC_CNT_RST)
		else $error("clear did not zero the count");

	chk_lsb_toggles: assert property ( // see [R6]
		counting ##1 (!ctrl.load && !ctrl.clear) |-> count_bit0_o != $past(count_bit0_o))
		else $error("least significant output did not toggle");

	chk_carry_pulse: assert property ( // see [R7]
		!carry_out_n_o ##1 (counting && ctrl.up == $past(ctrl.up) && !ctrl.load) |-> carry_out_n_o)
		else $error("chain output low longer than one cycle");

	chk_carry_at_term: assert property ( // see [R7]
		counting && cnt == (ctrl.up ? `BUDC_TC_UP : `BUDC_TC_DOWN) |-> !carry_out_n_o)
		else $error("chain output missed terminal count");

	chk_resume_load: assert property ( // see [R8]
		$fell(ctrl.load) && !ctrl.clear && !$past(ctrl.clear) |-> cnt == $past(ctrl.preset))
		else $error("count did not resume from loaded value");

	chk_carry_gate: assert property ( // see [R11]
		carry_in_n_i |-> carry_out_n_o)
		else $error("chain output low with chain input high");

	// Wrap, output and chain cross-checks; load and clear override the view, so
	// all but the two wrap checks and chk_carry_quiet look at the pins or the view, not only the stored count
	chk_up_wrap: assert property ( // see [R1]
		counting && ctrl.up && cnt == `BUDC_TC_UP |=> cnt == `BUDC_TC_DOWN)
		else $error("up count did not wrap to zero");

	chk_down_wrap: assert property ( // see [R2]
		counting && !ctrl.up && cnt == `BUDC_TC_DOWN |=> cnt == `BUDC_TC_UP)
		else $error("down count did not wrap to fifteen");

	chk_hold_view: assert property ( // see [R3]
		carry_in_n_i && !ctrl.load && !ctrl.clear ##1 !ctrl.load && !ctrl.clear
		|-> $stable({count_bit3_o, count_bit2_o, count_bit1_o, count_bit0_o}))
		else $error("count outputs moved while chain input high");

	chk_clear_first: assert property ( // see [R5]
		ctrl.clear && ctrl.load |-> count_view == `BUDC_CNT_RST)
		else $error("load overrode clear");

	chk_view_count: assert property ( // see [R6]
		!ctrl.clear && !ctrl.load |-> {count_bit3_o, count_bit2_o, count_bit1_o, count_bit0_o} == cnt)
		else $error("count outputs differ from stored count");

	chk_carry_term_only: assert property ( // see [R7]
		!carry_out_n_o |-> count_view == (ctrl.up ? `BUDC_TC_UP : `BUDC_TC_DOWN))
		else $error("chain output low away from terminal count");

	chk_carry_quiet: assert property ( // see [R7]
		ctrl.clear || ctrl.load |-> carry_out_n_o)
		else $error("chain output low during load or clear");

	// Main scenarios
	cov_wrap_up: cover property (counting && ctrl.up && cnt == `BUDC_TC_UP ##1 cnt == `BUDC_TC_DOWN);
	cov_wrap_down: cover property (counting && !ctrl.up && cnt == `BUDC_TC_DOWN ##1 cnt == `BUDC_TC_UP);
	cov_load_resume: cover property ($fell(ctrl.load) ##1 counting);
	cov_carry_low: cover property (!carry_out_n_o);
	cov_chain_hold: cover property (carry_in_n_i && !ctrl.load && !ctrl.clear ##1 carry_in_n_i);

endmodule

// ---- inc/budc_params.svh ----
// Constants for the 4-bit binary up/down counter block
// Notes on behaviour
// [R1] Each clock edge with no inhibit moves the 4-bit count by one step.
// [R2] The count rises while direction is high and falls while it is low.
// [R3] The active-low chain input held high freezes the count.
// [R4] A high load strobe copies the preset value into the count at once and blocks counting.
// [R5] A high clear forces the count to zero at once and blocks counting.
// [R6] The count appears on four outputs, bit 0 being the least significant.
// [R7] The active-low chain output is low for one whole cycle at 15 counting up or 0 counting down.
// [R8] Once the load strobe drops, counting resumes from the loaded value.
// [R9] Cascaded stages join chain output to the next chain input and share one clock.
// [R10] A two-stage divider counts down from a nonzero ratio of at most 255.
// [R11] The chain output only goes low while this stage's own chain input is low.
`ifndef BUDC_PARAMS_SVH
`define BUDC_PARAMS_SVH

// Register byte offsets
`define BUDC_OFS_CTRL 32'h00000000
`define BUDC_OFS_STAT 32'h00000004

// Control word fields
`define BUDC_CTRL_UP 0
`define BUDC_CTRL_LOAD 1
`define BUDC_CTRL_CLEAR 2
`define BUDC_CTRL_PRE_LO 4
`define BUDC_CTRL_PRE_HI 7
`define BUDC_CTRL_RST 8'h00

// Status word fields
`define BUDC_STAT_CNT_LO 0
`define BUDC_STAT_CNT_HI 3
`define BUDC_STAT_COUT 4
`define BUDC_STAT_CIN 5

// Count values
`define BUDC_CNT_RST 4'h0
`define BUDC_CNT_STEP 4'h1
`define BUDC_TC_UP 4'hF
`define BUDC_TC_DOWN 4'h0

// AHB-Lite encodings
`define BUDC_HRESP_OKAY 1'b0
`define BUDC_RDATA_ZERO 32'h00000000

`endif

// ---- inc/budc_pkg.sv ----
// Types used by the counter core for its control and status words
package budc_pkg;

	// Software control word, low byte of the control register
	typedef struct packed {
		logic [3:0] preset;
		logic spare;
		logic clear;
		logic load;
		logic up;
	} budc_ctrl_t;

	// Counter state seen by software
	typedef struct packed {
		logic cin_n;
		logic cout_n;
		logic [3:0] count;
	} budc_stat_t;

endpackage

// ---- core/budc_ahb_slave.sv ----
// AHB-Lite slave front end for the counter registers
`timescale 1ns/1ps
`include "budc_params.svh"

module budc_ahb_slave (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// AHB-Lite slave side
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Register side
	input wire logic [31:0] ctrl_word_i,
	input wire logic [31:0] stat_word_i,
	output logic ctrl_wr_o,
	output logic [31:0] wdata_o
);

	logic dp_wr;
	logic [31:0] dp_addr;
	logic next_dp_wr;
	logic [31:0] next_dp_addr;
	logic [31:0] next_rdata;
	logic take;

	// Only word transfers are issued, so hsize needs no decode
	assign take = hsel_i & htrans_i[1] & hready_i;

	// Address phase capture; read data is fetched early so the data phase has no wait
	always_comb begin
		next_dp_wr = take & hwrite_i;
		next_dp_addr = take ? haddr_i : dp_addr;
		next_rdata = hrdata_o;
		if (take & ~hwrite_i) begin
			case (haddr_i)
				`BUDC_OFS_CTRL: next_rdata = ctrl_word_i;
				`BUDC_OFS_STAT: next_rdata = stat_word_i;
				default: next_rdata = `BUDC_RDATA_ZERO;
			endcase
		end
	end

	// Register the phase state
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			dp_wr <= 1'b0;
			dp_addr <= `BUDC_OFS_CTRL;
			hrdata_o <= `BUDC_RDATA_ZERO;
		end else begin
			dp_wr <= next_dp_wr;
			dp_addr <= next_dp_addr;
			hrdata_o <= next_rdata;
		end
	end

	// Zero wait states; writes to the status word or unmapped space are dropped
	assign hreadyout_o = 1'b1;
	assign hresp_o = `BUDC_HRESP_OKAY;
	assign ctrl_wr_o = dp_wr & (dp_addr == `BUDC_OFS_CTRL);
	assign wdata_o = hwdata_i;

endmodule

// ---- dv/budc_chain_src.sv ----
// Model of the lower cascade stage that feeds the chain input
`timescale 1ns/1ps
module budc_chain_src (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Control from the bench
	input wire logic en_i,
	input wire logic [3:0] period_i,
	// Chain output, active low
	output logic carry_n_o
);
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	// Counts down from the period; a period of zero keeps the chain enabled every cycle
	always_comb begin
		next_cnt = cnt - 4'h1;
		if (!nrst_i || !en_i || cnt == 4'h0) begin
			next_cnt = period_i;
		end
	end
	// Same clock as the counter, so the pulse lines up with its edges
	always_ff @(posedge clock_i) begin
		cnt <= next_cnt;
	end
	// Disabled stage parks the chain high, which inhibits the counter
	assign carry_n_o = !(en_i && cnt == 4'h0);
endmodule

// ---- dv/budc_counter_tb_top.sv ----
// Self-checking bench for the up/down counter and its register bus
`timescale 1ns/1ps
module budc_counter_tb_top;
	logic clk, nrst, hsel, hwrite, en, hready, hresp, cout, cin;
	logic [31:0] haddr, hwdata, hrdata, x;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] per, p, pins, e, rcnt;
	logic [7:0] rctl;
	logic up, wph, rph;
	logic [31:0] expq[$];
	int fail_count, num_checks, cyc, i;

	budc_counter i_budc_counter (.clock_i(clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .carry_in_n_i(cin),
		.carry_out_n_o(cout), .count_bit0_o(pins[0]), .count_bit1_o(pins[1]),
		.count_bit2_o(pins[2]), .count_bit3_o(pins[3]));
	budc_chain_src i_budc_chain_src (.clock_i(clk), .nrst_i(nrst), .en_i(en), .period_i(per),
		.carry_n_o(cin));

	always #5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask

	task automatic finish_test();
		if (fail_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One single word transfer; a read notes its expected data first
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] want);
		if (!wr) expq.push_back(want);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= a;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
	endtask

	// Reference model and output watcher, using values from before each edge
	always @(posedge clk) begin
		if (!nrst) begin
			rcnt = 4'h0;
			rctl = 8'h00;
			wph = 1'b0;
			rph = 1'b0;
		end else begin
			e = rctl[2] ? 4'h0 : (rctl[1] ? rctl[7:4] : rcnt);
			check({28'h0, pins}, {28'h0, e});
			check({31'h0, cout}, {31'h0, !(!cin && rctl[2:1] == 2'b00 && e == (rctl[0] ? 4'hF : 4'h0))});
			check({31'h0, hresp}, 32'h0);
			if (rph) begin
				x = expq.pop_front();
				check(hrdata, x);
			end
			// Clear outranks load; counting only with the chain low
			if (rctl[2]) rcnt = 4'h0;
			else if (rctl[1]) rcnt = rctl[7:4];
			else if (!cin) rcnt = rctl[0] ? rcnt + 4'h1 : rcnt - 4'h1;
			if (wph) rctl = hwdata[7:0];
			wph = hsel && htrans[1] && hwrite && haddr == 32'h0;
			rph = hsel && htrans[1] && !hwrite;
		end
	end

	// Cut a hang short well beyond the expected run of under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			finish_test();
		end
	end

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		en = 1'b1;
		per = 4'h0;
		void'($urandom(32'h9467d257));
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// Reset value, read-only and unmapped places
		bus(1'b0, 32'h0, 32'h0, 32'h0);
		bus(1'b1, 32'h4, 32'hFF, 32'h0);
		bus(1'b0, 32'h8, 32'h0, 32'h0);
		bus(1'b0, 32'h0, 32'h0, 32'h0);
		// First two runs cross both terminal counts, the rest are random
		for (i = 0; i < 10; i++) begin
			p = (i == 0) ? 4'hE : ((i == 1) ? 4'h1 : 4'($urandom));
			up = (i == 0) ? 1'b1 : ((i == 1) ? 1'b0 : 1'($urandom));
			per <= (i < 2) ? 4'h0 : 4'($urandom);
			bus(1'b1, 32'h0, {24'h0, p, 3'b001, up}, 32'h0);
			bus(1'b1, 32'h0, {24'h0, p, 3'b000, up}, 32'h0);
			repeat (40) @(posedge clk);
		end
		// Clear and load together, read straight back
		bus(1'b1, 32'h0, 32'h56, 32'h0);
		bus(1'b0, 32'h0, 32'h0, 32'h56);
		bus(1'b1, 32'h0, 32'h01, 32'h0);
		repeat (5) @(posedge clk);
		// Chain held high freezes the count
		en <= 1'b0;
		repeat (4) @(posedge clk);
		bus(1'b0, 32'h4, 32'h0, {26'h0, 2'b11, rcnt});
		// Divider use: both stages count down from a nonzero ratio
		p = 4'($urandom_range(15, 1));
		per <= 4'($urandom_range(15, 1));
		en <= 1'b1;
		bus(1'b1, 32'h0, {24'h0, p, 3'b001, 1'b0}, 32'h0);
		bus(1'b1, 32'h0, {24'h0, p, 3'b000, 1'b0}, 32'h0);
		repeat (60) @(posedge clk);
		repeat (2) @(posedge clk);
		finish_test();
	end
endmodule
